// ==== msr_top.v ====
// send request checker: validates a send parameter set, copies the
// selected field of a data block into the coordinator buffer.
// assumes block info, word memory and buffer all run on pclk; word
// memory answers a read in the same cycle as mem_rd.
//
// Notes on behaviour
// [RULE1] requester gives destination 1..4, not own
// [RULE2] bad destination answers code 65
// [RULE3] type 1 standard, 2 extended, else 69
// [RULE4] reserved blocks 0..2 answer code 70
// [RULE5] missing block answers code 71
// [RULE6] field n covers words 32n..32n+31
// [RULE7] short last field sends 1..32 words
// [RULE8] field past block end: code 72
// [RULE9] active lower level call answers 67
// [RULE10] no init or corrupt own number: 67
// [RULE11] inconsistent queue data answers code 68
// [RULE12] zero capacity: nothing sent, code 129
// [RULE13] requester repeats after a warning
// [RULE14] no initialization conflict codes ever
// [RULE15] requester lays out six parameter bytes; the PARAM register takes four
// [RULE16] report remaining capacity of the link
// [RULE17] copy field into destination link buffer
// [RULE18] success: capacity minus one, code 0
`timescale 1ns/1ps
`include "msr_consts.vh"

module msr_top #(
  parameter LEN_W = 16
) (
  input wire pclk, // bus clock
  input wire presetn, // async reset, low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error
  output wire irq, // level interrupt
  input wire lower_level_active, // comm call busy below
  input wire queue_bad, // link queue data broken
  output wire [7:0] blk_type, // queried block type
  output wire [7:0] blk_num, // queried block number
  input wire blk_exists, // block present
  input wire [LEN_W-1:0] blk_len, // block length words
  output reg mem_rd, // word read strobe
  output reg [LEN_W-1:0] mem_addr, // block_word index
  input wire [15:0] mem_data, // word in the mem_rd cycle
  output reg buf_valid, // buffer word valid
  input wire buf_ready, // buffer takes word
  output reg [15:0] buf_data, // buffer word
  output reg [1:0] buf_link, // link index dest-1
  output reg buf_last // last word of field
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_LOOK = 3'd1;
  localparam ST_EVAL = 3'd2;
  localparam ST_READ = 3'd3;
  localparam ST_WAIT = 3'd4;
  localparam ST_SEND = 3'd5;

  reg [2:0] state_r;
  reg [2:0] state_nxt;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg init_ok_r;
  reg [2:0] own_r;
  reg [7:0] dest_r;
  reg [7:0] type_r;
  reg [7:0] num_r;
  reg [7:0] field_r;
  reg [7:0] cc_r;
  reg [31:0] cap_r;
  reg [2:0] int_stat_r;
  reg [2:0] int_mask_r;
  reg exists_r;
  reg [LEN_W-1:0] len_r;
  reg [LEN_W-1:0] end_r;
  reg [LEN_W-1:0] addr_r;

  wire wr_en;
  wire rd_en;
  wire busy;
  wire start;
  wire [1:0] link;
  wire [7:0] link_cap;
  wire [LEN_W-1:0] first_w;
  wire [LEN_W-1:0] room_w;
  wire [LEN_W-1:0] end_w;
  wire dest_bad;
  wire call_bad;
  wire type_bad;
  wire rsvd_bad;
  wire field_bad;
  wire ev_done;
  wire ev_warn;
  wire ev_err;
  reg [7:0] cc_nxt;
  reg addr_hit;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign busy = (state_r != ST_IDLE);
  // start ignored while a request is running
  assign start = wr_en && (paddr == `MSR_OFF_CTRL) && pwdata[`MSR_CTRL_START] && !busy;
  assign blk_type = type_r;
  assign blk_num = num_r;
  assign link = dest_r[1:0] - 2'b01;
  // [RULE16] capacity of selected link
  assign link_cap = cap_r[{link, 3'b000} +: 8];

  always @* begin
    case (paddr)
      `MSR_OFF_CTRL, `MSR_OFF_PARAM, `MSR_OFF_RESULT,
      `MSR_OFF_CAP, `MSR_OFF_INT_STAT, `MSR_OFF_INT_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (paddr)
        `MSR_OFF_CTRL: prdata = {21'h000000, own_r, 6'h00, init_ok_r, 1'b0};
        `MSR_OFF_PARAM: prdata = {field_r, num_r, type_r, dest_r};
        `MSR_OFF_RESULT: prdata = {15'h0000, busy, link_cap, cc_r};
        `MSR_OFF_CAP: prdata = cap_r;
        `MSR_OFF_INT_STAT: prdata = {29'h00000000, int_stat_r};
        `MSR_OFF_INT_MASK: prdata = {29'h00000000, int_mask_r};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // [RULE2] destination range and own number
  assign dest_bad = (dest_r < `MSR_CPU_MIN) || (dest_r > `MSR_CPU_MAX) ||
                    (dest_r == {5'h00, own_r});
  // [RULE9] [RULE10] call sequence checks
  assign call_bad = lower_level_active || !init_ok_r ||
                    (own_r == 3'h0) || (own_r > `MSR_CPU_MAX);
  // [RULE3] only two block types
  assign type_bad = (type_r != `MSR_TYPE_STD) && (type_r != `MSR_TYPE_EXT);
  // [RULE4] reserved block numbers
  assign rsvd_bad = (num_r <= `MSR_RSVD_LAST);
  // [RULE6] field start is 32 times n
  assign first_w = {{(LEN_W-13){1'b0}}, field_r, 5'b00000};
  // [RULE8] first word beyond block end
  assign field_bad = (first_w >= len_r);
  assign room_w = len_r - first_w;
  // [RULE7] clip field at block end
  assign end_w = (room_w > `MSR_FIELD_WORDS) ? (first_w + `MSR_FIELD_WORDS - 1'b1)
                                             : (len_r - 1'b1);

  // [RULE14] only error, warning or success codes
  always @* begin
    if (call_bad)
      cc_nxt = `MSR_CC_CALL;
    else if (dest_bad)
      cc_nxt = `MSR_CC_DEST;
    else if (type_bad)
      cc_nxt = `MSR_CC_TYPE;
    else if (rsvd_bad)
      cc_nxt = `MSR_CC_RSVD;
    // [RULE5] nonexistent block
    else if (!exists_r)
      cc_nxt = `MSR_CC_NOBLK;
    else if (field_bad)
      cc_nxt = `MSR_CC_FIELD;
    // [RULE11] broken queue management data
    else if (queue_bad)
      cc_nxt = `MSR_CC_QUEUE;
    // [RULE12] buffer full warning
    else if (link_cap == 8'h00)
      cc_nxt = `MSR_CC_FULL;
    else
      cc_nxt = `MSR_CC_OK;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start) state_nxt = ST_LOOK;
      ST_LOOK: state_nxt = ST_EVAL;
      ST_EVAL: state_nxt = (cc_nxt == `MSR_CC_OK) ? ST_READ : ST_IDLE;
      ST_READ: state_nxt = ST_WAIT;
      ST_WAIT: state_nxt = ST_SEND;
      ST_SEND: begin
        if (buf_ready)
          state_nxt = buf_last ? ST_IDLE : ST_READ;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign ev_done = (state_r == ST_SEND) && buf_ready && buf_last;
  assign ev_warn = (state_r == ST_EVAL) && (cc_nxt == `MSR_CC_FULL);
  assign ev_err = (state_r == ST_EVAL) && (cc_nxt != `MSR_CC_FULL) &&
                  (cc_nxt != `MSR_CC_OK);
  assign irq = |(int_stat_r & int_mask_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      init_ok_r <= 1'b0;
      own_r <= `MSR_RST_OWN;
      dest_r <= 8'h00;
      type_r <= 8'h00;
      num_r <= 8'h00;
      field_r <= 8'h00;
      cc_r <= `MSR_CC_OK;
      cap_r <= `MSR_RST_CAP;
      int_stat_r <= 3'h0;
      int_mask_r <= `MSR_RST_MASK;
      exists_r <= 1'b0;
      len_r <= {LEN_W{1'b0}};
      end_r <= {LEN_W{1'b0}};
      addr_r <= {LEN_W{1'b0}};
      mem_rd <= 1'b0;
      mem_addr <= {LEN_W{1'b0}};
      buf_valid <= 1'b0;
      buf_data <= 16'h0000;
      buf_link <= 2'b00;
      buf_last <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mem_rd <= 1'b0;
      if (wr_en && (paddr == `MSR_OFF_CTRL)) begin
        init_ok_r <= pwdata[`MSR_CTRL_INIT_OK];
        own_r <= pwdata[`MSR_CTRL_OWN_LSB +: 3];
      end
      // parameters frozen while busy
      if (wr_en && (paddr == `MSR_OFF_PARAM) && !busy) begin
        dest_r <= pwdata[7:0];
        type_r <= pwdata[15:8];
        num_r <= pwdata[23:16];
        field_r <= pwdata[31:24];
      end
      if (wr_en && (paddr == `MSR_OFF_INT_MASK))
        int_mask_r <= pwdata[2:0];
      // set wins over a same-cycle clear
      if (wr_en && (paddr == `MSR_OFF_INT_STAT))
        int_stat_r <= (int_stat_r & ~pwdata[2:0]) | {ev_err, ev_warn, ev_done};
      else
        int_stat_r <= int_stat_r | {ev_err, ev_warn, ev_done};
      if (state_r == ST_LOOK) begin
        exists_r <= blk_exists;
        len_r <= blk_len;
      end
      if (state_r == ST_EVAL) begin
        cc_r <= cc_nxt;
        end_r <= end_w;
        addr_r <= first_w;
      end
      // [RULE17] fetch next block word
      if (state_r == ST_READ) begin
        mem_rd <= 1'b1;
        mem_addr <= addr_r;
      end
      if (state_r == ST_WAIT) begin
        buf_valid <= 1'b1;
        buf_data <= mem_data;
        buf_link <= link;
        buf_last <= (addr_r == end_r);
      end
      if ((state_r == ST_SEND) && buf_ready) begin
        buf_valid <= 1'b0;
        buf_last <= 1'b0;
        addr_r <= addr_r + 1'b1;
      end
      // [RULE18] take one field of capacity
      if (ev_done)
        cap_r[{link, 3'b000} +: 8] <= link_cap - 8'h01;
      else if (wr_en && (paddr == `MSR_OFF_CAP) && !busy)
        cap_r <= pwdata;
    end
  end

endmodule

// ==== msr_consts.vh ====
// constants for the multiprocessor send request checker
// assumes inclusion by bare name from msr_top.v
`ifndef MSR_CONSTS_VH
`define MSR_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MSR_OFF_CTRL 12'h000
`define MSR_OFF_PARAM 12'h004
`define MSR_OFF_RESULT 12'h008
`define MSR_OFF_CAP 12'h00c
`define MSR_OFF_INT_STAT 12'h010
`define MSR_OFF_INT_MASK 12'h014

// ----------------------------------------
// field positions
// ----------------------------------------
`define MSR_CTRL_START 0
`define MSR_CTRL_INIT_OK 1
`define MSR_CTRL_OWN_LSB 8
`define MSR_RES_BUSY 16
`define MSR_INT_DONE 0
`define MSR_INT_WARN 1
`define MSR_INT_ERR 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define MSR_RST_OWN 3'h0
`define MSR_RST_CAP 32'h00000000
`define MSR_RST_MASK 3'h0

// ----------------------------------------
// limits and condition codes
// ----------------------------------------
`define MSR_CPU_MIN 8'h01
`define MSR_CPU_MAX 8'h04
`define MSR_TYPE_STD 8'h01
`define MSR_TYPE_EXT 8'h02
`define MSR_RSVD_LAST 8'h02
`define MSR_FIELD_WORDS 16'h0020
`define MSR_CC_OK 8'h00
`define MSR_CC_DEST 8'h41
`define MSR_CC_CALL 8'h43
`define MSR_CC_QUEUE 8'h44
`define MSR_CC_TYPE 8'h45
`define MSR_CC_RSVD 8'h46
`define MSR_CC_NOBLK 8'h47
`define MSR_CC_FIELD 8'h48
`define MSR_CC_FULL 8'h81

`endif

// ==== msr_far_model.sv ====
// far side model: block directory, word memory, coordinator buffer
// assumes one pclk domain; slow makes the buffer stall at random
`timescale 1ns/1ps
module msr_far (
  input wire pclk, // clock
  input wire clr, // clear tallies
  input wire slow, // stall buffer
  input wire [7:0] blk_num, // queried block
  output wire blk_exists, // block present
  output wire [15:0] blk_len, // length in words
  input wire mem_rd, // read strobe
  input wire [15:0] mem_addr, // word index
  output wire [15:0] mem_data, // word
  input wire buf_valid, // word offered
  output reg buf_ready = 1'b0, // word taken
  input wire [15:0] buf_data, // word
  input wire [1:0] buf_link, // link index
  output reg [7:0] nw = 8'h00, // words taken
  output reg [15:0] xs = 16'h0000, // xor of words
  output reg [1:0] lk = 2'h0 // last link
);
  // block 15 missing; four words per block number
  assign blk_exists = blk_num != 8'h0f;
  assign blk_len = {6'h00, blk_num, 2'b00};
  reg [15:0] old_r = 16'h0000;
  // word stands while mem_rd is high; otherwise the inverse of the last word,
  // so a sample taken one cycle late sees the inverted word, not the valid one
  assign mem_data = mem_rd ? (mem_addr ^ 16'h5a5a) : ~old_r;
  always @(posedge pclk) begin
    old_r <= mem_data;
    buf_ready <= !slow || ($random & 1) != 0;
    if (clr) begin
      nw <= 8'h00;
      xs <= 16'h0000;
    end else if (buf_valid && buf_ready) begin
      nw <= nw + 8'h01;
      xs <= xs ^ buf_data;
      lk <= buf_link;
    end
  end
endmodule

// ==== msr_top_checker.sv ====
// assertions on the word fetch and buffer hand-off of msr_top
// assumes pclk only; bound to msr_top below
`timescale 1ns/1ps
module msr_chk #(parameter LEN_W = 16) (
  input wire pclk, // clock
  input wire presetn, // reset, low
  input wire [7:0] blk_type, // type
  input wire [7:0] blk_num, // number
  input wire blk_exists, // present
  input wire [LEN_W-1:0] blk_len, // length
  input wire mem_rd, // read strobe
  input wire [LEN_W-1:0] mem_addr, // index
  input wire [15:0] mem_data, // word
  input wire buf_valid, // valid
  input wire buf_ready, // ready
  input wire [15:0] buf_data, // data
  input wire buf_last // last
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg mid_r;
  reg [LEN_W-1:0] la_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_r <= 1'b0;
      la_r <= {LEN_W{1'b0}};
    end else if (mem_rd) begin
      mid_r <= 1'b1;
      la_r <= mem_addr;
    end else if (buf_valid && buf_ready && buf_last) begin
      mid_r <= 1'b0;
    end
  end
  sequence s_rd; mem_rd ##1 !mem_rd [*2]; endsequence
  property p_fetch; mem_rd |=> buf_valid && buf_data == $past(mem_data); endproperty
  property p_gap; mem_rd |-> s_rd; endproperty
  property p_hold; buf_valid && !buf_ready |=> buf_valid && $stable(buf_data); endproperty
  property p_step; mem_rd && mid_r |-> mem_addr == la_r + 1'b1; endproperty
  property p_start; mem_rd && !mid_r |-> mem_addr[4:0] == 5'h00; endproperty
  property p_inblk; mem_rd |-> mem_addr < blk_len; endproperty
  property p_last; buf_valid |-> buf_last == (la_r[4:0] == 5'h1f || la_r == blk_len - 1'b1);
  endproperty
  property p_blk; mem_rd |-> blk_exists && blk_num > 8'h02 && blk_type inside {8'h01, 8'h02};
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetched word not offered");
  a_gap: assert property (p_gap) else $error("word reads too close");
  a_hold: assert property (p_hold) else $error("offered word dropped");
  a_step: assert property (p_step) else $error("word index skipped");
  a_start: assert property (p_start) else $error("field start misaligned");
  a_inblk: assert property (p_inblk) else $error("read beyond block");
  a_last: assert property (p_last) else $error("last flag wrong");
  a_blk: assert property (p_blk) else $error("sent from bad block");
endmodule
bind msr_top msr_chk #(.LEN_W(LEN_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .blk_type(blk_type), .blk_num(blk_num), .blk_exists(blk_exists), .blk_len(blk_len),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data), .buf_valid(buf_valid),
  .buf_ready(buf_ready), .buf_data(buf_data), .buf_last(buf_last));

// ==== msr_top_tb.sv ====
// self-checking bench: corner and random send requests over apb
// assumes msr_far stands in for the buffer, directory and memory
`timescale 1ns/1ps
`include "msr_consts.vh"
module msr_top_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg lla = 1'b0, qb = 1'b0, slow = 1'b0, clr = 1'b0, cfg = 1'b0, perr;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, q;
  reg [7:0] cap [0:3];
  reg [2:0] mask = 3'h5;
  wire [31:0] prdata;
  wire pready, pslverr, irq, blk_exists, mem_rd, buf_valid, buf_ready, buf_last;
  wire [7:0] blk_type, blk_num, nw;
  wire [15:0] blk_len, mem_addr, mem_data, buf_data, xs;
  wire [1:0] buf_link, lk;
  integer n_errors = 0, num_checks = 0, cyc = 0, seed = 38262, i, k;
  always #5 pclk = ~pclk;
  msr_top #(.LEN_W(16)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .lower_level_active(lla), .queue_bad(qb),
    .blk_type(blk_type), .blk_num(blk_num), .blk_exists(blk_exists), .blk_len(blk_len),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data), .buf_valid(buf_valid),
    .buf_ready(buf_ready), .buf_data(buf_data), .buf_link(buf_link), .buf_last(buf_last));
  msr_far u_far (.pclk(pclk), .clr(clr), .slow(slow), .blk_num(blk_num),
    .blk_exists(blk_exists), .blk_len(blk_len), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_data(mem_data), .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_data(buf_data),
    .buf_link(buf_link), .nw(nw), .xs(xs), .lk(lk));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // request held until the edge where pready is seen high; answer taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    reg r;
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      r = 1'b0;
      while (!r) begin
        @(posedge pclk);
        {r, q, perr} = {pready, prdata, pslverr};
      end
      {psel, penable} <= 2'b00;
    end
  endtask
  function [7:0] exp_cc(input [7:0] d, t, n, f);
    if (lla || !cfg) exp_cc = `MSR_CC_CALL;
    else if (d < 1 || d > 4 || d == 1) exp_cc = `MSR_CC_DEST;
    else if (t != 1 && t != 2) exp_cc = `MSR_CC_TYPE;
    else if (n <= 2) exp_cc = `MSR_CC_RSVD;
    else if (n == 15) exp_cc = `MSR_CC_NOBLK;
    else if (32 * f >= 4 * n) exp_cc = `MSR_CC_FIELD;
    else if (qb) exp_cc = `MSR_CC_QUEUE;
    else if (cap[d-1] == 0) exp_cc = `MSR_CC_FULL;
    else exp_cc = `MSR_CC_OK;
  endfunction
  task setcap;
    begin
      for (k = 0; k < 4; k = k + 1) cap[k] = {$random(seed)} % 4;
      apb(1'b1, `MSR_OFF_CAP, {cap[3], cap[2], cap[1], cap[0]});
      apb(1'b0, `MSR_OFF_CAP, 32'h0);
      chk("cap reg", q, {cap[3], cap[2], cap[1], cap[0]});
    end
  endtask
  // four-byte parameter set, one request, repeated later to reach a warning
  task req(input [7:0] d, t, n, f);
    reg [7:0] c;
    reg [15:0] e;
    integer a, ln;
    begin
      clr <= 1'b1;
      apb(1'b1, `MSR_OFF_INT_MASK, {29'h0, mask});
      apb(1'b1, `MSR_OFF_PARAM, {f, n, t, d});
      clr <= 1'b0;
      apb(1'b1, `MSR_OFF_CTRL, cfg ? 32'h0103 : 32'h0001);
      c = exp_cc(d, t, n, f);
      q = 32'h00010000;
      for (k = 0; k < 400 && q[16]; k = k + 1) apb(1'b0, `MSR_OFF_RESULT, 32'h0);
      chk("code", q[7:0], c);
      {e, ln} = 0;
      for (a = 32 * f; c == 0 && a < 32 * f + 32 && a < 4 * n; a = a + 1) begin
        e = e ^ a[15:0] ^ 16'h5a5a;
        ln = ln + 1;
      end
      if (c == 0) cap[d-1] = cap[d-1] - 8'h01;
      chk("words", nw, ln);
      chk("data", xs, e);
      if (ln > 0) chk("link", lk, d - 8'h01);
      if (d >= 1 && d <= 4) chk("capacity", q[15:8], cap[d-1]);
      apb(1'b0, `MSR_OFF_INT_STAT, 32'h0);
      e = c == 0 ? 16'h1 : c == `MSR_CC_FULL ? 16'h2 : 16'h4;
      chk("status", q, e);
      chk("irq", irq, |(e[2:0] & mask));
      apb(1'b1, `MSR_OFF_INT_STAT, 32'h7);
      @(negedge pclk);
      chk("irq clear", irq, 1'b0);
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", {q, perr}, 33'h1);
    req(2, 1, 20, 0);
    setcap;
    apb(1'b1, `MSR_OFF_CTRL, 32'h0502);
    req(2, 1, 20, 0);
    cfg = 1'b1;
    cap[3] = 8'h01;
    cap[1] = 8'h03;
    apb(1'b1, `MSR_OFF_CAP, {cap[3], cap[2], cap[1], cap[0]});
    apb(1'b1, `MSR_OFF_CTRL, 32'h0102);
    mask = 3'h7;
    req(4, 1, 20, 2);
    req(4, 1, 20, 2);
    req(2, 2, 8, 0);
    req(2, 1, 20, 3);
    req(1, 1, 20, 0);
    req(5, 1, 20, 0);
    req(0, 1, 20, 0);
    req(2, 0, 20, 0);
    req(2, 3, 20, 0);
    req(2, 1, 2, 0);
    req(2, 2, 15, 0);
    qb <= 1'b1;
    req(3, 1, 20, 1);
    {qb, lla} <= 2'b01;
    req(3, 1, 20, 1);
    for (i = 0; i < 30; i = i + 1) begin
      if (i % 10 == 0) setcap;
      lla <= ({$random(seed)} % 8) == 0;
      qb <= ({$random(seed)} % 8) == 0;
      slow <= ($random(seed) & 1) != 0;
      mask = $random(seed);
      req({$random(seed)} % 6, {$random(seed)} % 4, {$random(seed)} % 24, {$random(seed)} % 4);
    end
    print_verdict;
  end
endmodule
